//--- core/cal_mem_pkg.sv
// constants for the calibration memory access control block
package cal_mem_pkg;
  // register indices count words: byte address = 4 * index
  localparam logic [7:0] IDX_CONTROL = 8'h0F;
  localparam logic [7:0] IDX_POINTER = 8'h10;
  localparam logic [7:0] IDX_VALUE = 8'h11;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h21;
  localparam logic [9:0] ADR_CONTROL = {IDX_CONTROL, 2'b00};
  localparam logic [9:0] ADR_POINTER = {IDX_POINTER, 2'b00};
  localparam logic [9:0] ADR_VALUE = {IDX_VALUE, 2'b00};
  localparam logic [9:0] ADR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [9:0] ADR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};
  // control register fields
  localparam int BIT_CAL_DONE = 7;
  localparam int BIT_CAL_RUN = 6;
  localparam int BIT_FUSE_DONE = 5;
  localparam int BIT_FUSE_RUN = 4;
  localparam int BIT_SMEM_WR = 3;
  localparam int BIT_SMEM_RD = 2;
  localparam int BIT_FMEM_RD = 1;
  // interrupt status fields
  localparam int IRQ_CAL_DONE = 0;
  localparam int IRQ_FUSE_DONE = 1;
  localparam int IRQ_ACCESS_DONE = 2;
  localparam int IRQ_W = 3;
  // reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_POINTER = 8'h00;
  localparam logic [5:0] RST_VALUE = 6'h00;
  // memory geometry and engine timing
  localparam int MEM_DEPTH = 256;
  localparam int CAL_CYCLES = 64;
  localparam logic [7:0] CAL_LAST = 8'h3F;
  localparam logic [7:0] FUSE_LAST = 8'hFF;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CAL = 4'b0010,
    ST_FUSE = 4'b0100,
    ST_ACCESS = 4'b1000
  } engine_state_t;
endpackage : cal_mem_pkg

//--- core/calibration_memory_access_control.sv
// control register, sequencer and memories for calibration and fuse access
// Behaviour
// - bit 7 reads calibration done
// - bit 6 set starts calibration, reads running
// - bit 5 reads fuse copy done
// - bit 4 set starts fuse copy, reads running
// - bit 3 writes value into static memory
// - bit 2 reads static memory into value
// - fuse read command loads fuse word to value
// - 8-bit pointer selects memory location
// - 6-bit value register carries memory word
`timescale 1ns/10ps
module calibration_memory_access_control (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // status and interrupt
  output logic cal_busy,
  output logic irq
);

  // fuse contents are factory programmed; modelled as a constant pattern
  function automatic logic [5:0] fuse_word(input logic [7:0] addr);
    fuse_word = addr[5:0] ^ {addr[7:6], addr[7:6], addr[7:6]};
  endfunction : fuse_word

  function automatic logic reg_hit(input logic [9:0] adr);
    reg_hit = (adr == cal_mem_pkg::ADR_CONTROL) || (adr == cal_mem_pkg::ADR_POINTER) ||
              (adr == cal_mem_pkg::ADR_VALUE) || (adr == cal_mem_pkg::ADR_IRQ_STATUS) ||
              (adr == cal_mem_pkg::ADR_IRQ_MASK);
  endfunction : reg_hit

  logic [7:0] calibration_memory_control;
  logic [7:0] mem_access_pointer;
  logic [5:0] mem_access_value;
  logic [cal_mem_pkg::IRQ_W-1:0] irq_status;
  logic [cal_mem_pkg::IRQ_W-1:0] irq_mask;
  logic [5:0] static_mem [cal_mem_pkg::MEM_DEPTH];
  logic [5:0] fuse_shadow [cal_mem_pkg::MEM_DEPTH];
  logic [7:0] step;
  cal_mem_pkg::engine_state_t state;
  cal_mem_pkg::engine_state_t next_state;

  logic req;
  logic wr_en;
  logic rd_en;
  logic wr_lane0;
  logic cal_start;
  logic fuse_start;
  logic access_start;
  logic cal_finish;
  logic fuse_finish;
  logic access_finish;
  logic [2:0] access_cmd;

  // one-wait-state answer: ack in the cycle after the request appears
  assign req = cyc_i && stb_i && !ack_o && !err_o;
  assign wr_en = req && we_i && reg_hit(adr_i);
  assign rd_en = req && !we_i && reg_hit(adr_i);
  assign wr_lane0 = wr_en && sel_i[0];
  assign cal_start = wr_lane0 && adr_i == cal_mem_pkg::ADR_CONTROL &&
                     dat_i[cal_mem_pkg::BIT_CAL_RUN] && state == cal_mem_pkg::ST_IDLE;
  assign fuse_start = wr_lane0 && adr_i == cal_mem_pkg::ADR_CONTROL && !cal_start &&
                      dat_i[cal_mem_pkg::BIT_FUSE_RUN] && state == cal_mem_pkg::ST_IDLE;
  assign access_cmd = {dat_i[cal_mem_pkg::BIT_SMEM_WR], dat_i[cal_mem_pkg::BIT_SMEM_RD],
                       dat_i[cal_mem_pkg::BIT_FMEM_RD]};
  assign access_start = wr_lane0 && adr_i == cal_mem_pkg::ADR_CONTROL && !cal_start &&
                        !fuse_start && (|access_cmd) && state == cal_mem_pkg::ST_IDLE;
  assign cal_finish = state == cal_mem_pkg::ST_CAL && step == cal_mem_pkg::CAL_LAST;
  assign fuse_finish = state == cal_mem_pkg::ST_FUSE && step == cal_mem_pkg::FUSE_LAST;
  assign access_finish = state == cal_mem_pkg::ST_ACCESS;

  always_comb begin
    next_state = state;
    unique case (state)
      cal_mem_pkg::ST_IDLE: begin
        if (cal_start) begin
          next_state = cal_mem_pkg::ST_CAL;
        end else if (fuse_start) begin
          next_state = cal_mem_pkg::ST_FUSE;
        end else if (access_start) begin
          next_state = cal_mem_pkg::ST_ACCESS;
        end
      end
      cal_mem_pkg::ST_CAL: begin
        if (cal_finish) begin
          next_state = cal_mem_pkg::ST_IDLE;
        end
      end
      cal_mem_pkg::ST_FUSE: begin
        if (fuse_finish) begin
          next_state = cal_mem_pkg::ST_IDLE;
        end
      end
      cal_mem_pkg::ST_ACCESS: begin
        next_state = cal_mem_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= cal_mem_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // engine step counter for calibration and fuse copy
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      step <= 8'h00;
    end else if (cal_start || fuse_start || state == cal_mem_pkg::ST_IDLE) begin
      step <= 8'h00;
    end else begin
      step <= step + 8'h01;
    end
  end

  // control register: run bits steer the engine, done bits report it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      calibration_memory_control <= cal_mem_pkg::RST_CONTROL;
    end else begin
      if (cal_start) begin
        calibration_memory_control[cal_mem_pkg::BIT_CAL_RUN] <= 1'b1;
        calibration_memory_control[cal_mem_pkg::BIT_CAL_DONE] <= 1'b0;
      end else if (cal_finish) begin
        calibration_memory_control[cal_mem_pkg::BIT_CAL_RUN] <= 1'b0;
        calibration_memory_control[cal_mem_pkg::BIT_CAL_DONE] <= 1'b1;
      end
      if (fuse_start) begin
        calibration_memory_control[cal_mem_pkg::BIT_FUSE_RUN] <= 1'b1;
        calibration_memory_control[cal_mem_pkg::BIT_FUSE_DONE] <= 1'b0;
      end else if (fuse_finish) begin
        calibration_memory_control[cal_mem_pkg::BIT_FUSE_RUN] <= 1'b0;
        calibration_memory_control[cal_mem_pkg::BIT_FUSE_DONE] <= 1'b1;
      end
      if (access_start) begin
        calibration_memory_control[cal_mem_pkg::BIT_SMEM_WR:cal_mem_pkg::BIT_FMEM_RD] <=
          access_cmd;
      end else if (access_finish) begin
        calibration_memory_control[cal_mem_pkg::BIT_SMEM_WR:cal_mem_pkg::BIT_FMEM_RD] <= 3'h0;
      end
    end
  end

  // pointer register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_access_pointer <= cal_mem_pkg::RST_POINTER;
    end else if (wr_lane0 && adr_i == cal_mem_pkg::ADR_POINTER) begin
      mem_access_pointer <= dat_i[7:0];
    end
  end

  // value register: written by software, loaded by memory reads
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_access_value <= cal_mem_pkg::RST_VALUE;
    end else if (access_finish &&
                 calibration_memory_control[cal_mem_pkg::BIT_SMEM_RD]) begin
      mem_access_value <= static_mem[mem_access_pointer];
    end else if (access_finish &&
                 calibration_memory_control[cal_mem_pkg::BIT_FMEM_RD]) begin
      mem_access_value <= fuse_shadow[mem_access_pointer];
    end else if (wr_lane0 && adr_i == cal_mem_pkg::ADR_VALUE) begin
      mem_access_value <= dat_i[5:0];
    end
  end

  // fuse shadow is the factory image, fixed at build
  generate
    for (genvar i = 0; i < cal_mem_pkg::MEM_DEPTH; i++) begin : g_fuse
      assign fuse_shadow[i] = fuse_word(8'(i));
    end
  endgenerate

  // static memory: fuse copy fills it, write command updates one word
  always_ff @(posedge sys_clk) begin
    if (state == cal_mem_pkg::ST_FUSE) begin
      static_mem[step] <= fuse_shadow[step];
    end else if (access_finish &&
                 calibration_memory_control[cal_mem_pkg::BIT_SMEM_WR]) begin
      static_mem[mem_access_pointer] <= mem_access_value;
    end
  end

  // sticky events; set wins over the clearing read
  logic [cal_mem_pkg::IRQ_W-1:0] events;
  assign events = {access_finish, fuse_finish, cal_finish};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= '0;
    end else if (rd_en && adr_i == cal_mem_pkg::ADR_IRQ_STATUS) begin
      irq_status <= events;
    end else begin
      irq_status <= irq_status | events;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= '0;
    end else if (wr_lane0 && adr_i == cal_mem_pkg::ADR_IRQ_MASK) begin
      irq_mask <= dat_i[cal_mem_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
      cal_busy <= 1'b0;
    end else begin
      irq <= |((irq_status | events) & irq_mask);
      cal_busy <= next_state == cal_mem_pkg::ST_CAL;
    end
  end

  // bus answer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req && reg_hit(adr_i);
      err_o <= req && !reg_hit(adr_i);
      dat_o <= 32'h0000_0000;
      if (rd_en) begin
        unique case (adr_i)
          cal_mem_pkg::ADR_CONTROL: dat_o <= {24'h000000, calibration_memory_control};
          cal_mem_pkg::ADR_POINTER: dat_o <= {24'h000000, mem_access_pointer};
          cal_mem_pkg::ADR_VALUE: dat_o <= {26'h0000000, mem_access_value};
          cal_mem_pkg::ADR_IRQ_STATUS: dat_o <= {29'h00000000, irq_status};
          default: dat_o <= {29'h00000000, irq_mask};
        endcase
      end
    end
  end

  // checks
  a_cal_done_after: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cal_finish |=> calibration_memory_control[cal_mem_pkg::BIT_CAL_DONE] &&
                   !calibration_memory_control[cal_mem_pkg::BIT_CAL_RUN])
    else $error("calibration done not reported");
  a_cal_run_time: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cal_start |=> calibration_memory_control[cal_mem_pkg::BIT_CAL_RUN] [*8] ##57
                  !calibration_memory_control[cal_mem_pkg::BIT_CAL_RUN])
    else $error("calibration run length wrong");
  a_fuse_done_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fuse_start |=> !calibration_memory_control[cal_mem_pkg::BIT_FUSE_DONE] ##256
                   calibration_memory_control[cal_mem_pkg::BIT_FUSE_DONE])
    else $error("fuse done timing wrong");
  a_fuse_run_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fuse_start |=> calibration_memory_control[cal_mem_pkg::BIT_FUSE_RUN])
    else $error("fuse run not set");
  a_smem_wr_store: assert property (@(posedge sys_clk) disable iff (!rst_n)
    access_finish && calibration_memory_control[cal_mem_pkg::BIT_SMEM_WR] |=>
    static_mem[$past(mem_access_pointer)] == $past(mem_access_value))
    else $error("static write lost");
  a_smem_rd_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
    access_finish && calibration_memory_control[cal_mem_pkg::BIT_SMEM_RD] |=>
    mem_access_value == static_mem[$past(mem_access_pointer)])
    else $error("static read wrong");
  a_fmem_rd_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
    access_start && dat_i[cal_mem_pkg::BIT_FMEM_RD] && !dat_i[cal_mem_pkg::BIT_SMEM_RD] |=> ##1
    mem_access_value == fuse_word(mem_access_pointer))
    else $error("fuse read wrong");
  a_ptr_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_lane0 && adr_i == cal_mem_pkg::ADR_POINTER |=> mem_access_pointer == $past(dat_i[7:0]))
    else $error("pointer write lost");
  a_access_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
    access_start |=> ##1 calibration_memory_control[3:1] == 3'h0)
    else $error("command bits not cleared");

  // bus answer checks
  a_ack_one_wait: assert property (@(posedge sys_clk) disable iff (!rst_n)
    req && reg_hit(adr_i) |=> ack_o && !err_o)
    else $error("ack not one cycle after request");
  a_ack_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_err_unmapped: assert property (@(posedge sys_clk) disable iff (!rst_n)
    req && !reg_hit(adr_i) |=> err_o && !ack_o)
    else $error("unmapped access not refused");
  a_data_idle_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !rd_en |=> dat_o == 32'h0000_0000)
    else $error("read data outside read answer");

  // engine and register checks
  a_busy_follows_run: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cal_busy == calibration_memory_control[cal_mem_pkg::BIT_CAL_RUN])
    else $error("busy output differs from run bit");
  a_runs_exclusive: assert property (@(posedge sys_clk) disable iff (!rst_n)
    calibration_memory_control[cal_mem_pkg::BIT_CAL_RUN] |->
    !calibration_memory_control[cal_mem_pkg::BIT_FUSE_RUN] &&
    calibration_memory_control[cal_mem_pkg::BIT_SMEM_WR:cal_mem_pkg::BIT_FMEM_RD] == 3'h0)
    else $error("command accepted during calibration");
  a_cal_done_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
    calibration_memory_control[cal_mem_pkg::BIT_CAL_DONE] && !cal_start |=>
    calibration_memory_control[cal_mem_pkg::BIT_CAL_DONE])
    else $error("calibration done dropped");
  a_fuse_done_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
    calibration_memory_control[cal_mem_pkg::BIT_FUSE_DONE] && !fuse_start |=>
    calibration_memory_control[cal_mem_pkg::BIT_FUSE_DONE])
    else $error("fuse done dropped");
  a_fuse_run_ends: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fuse_finish |=> !calibration_memory_control[cal_mem_pkg::BIT_FUSE_RUN] &&
                    calibration_memory_control[cal_mem_pkg::BIT_FUSE_DONE])
    else $error("fuse run not ended");
  a_fuse_fill_word: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == cal_mem_pkg::ST_FUSE |=> static_mem[$past(step)] == fuse_shadow[$past(step)])
    else $error("fuse copy word wrong");
  a_ptr_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(wr_lane0 && adr_i == cal_mem_pkg::ADR_POINTER) |=> $stable(mem_access_pointer))
    else $error("pointer changed without write");
  a_value_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !access_finish && !(wr_lane0 && adr_i == cal_mem_pkg::ADR_VALUE) |=>
    $stable(mem_access_value))
    else $error("value changed without cause");
  a_value_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_lane0 && adr_i == cal_mem_pkg::ADR_VALUE && !access_finish |=>
    mem_access_value == $past(dat_i[5:0]))
    else $error("value write lost");

  // interrupt checks
  a_status_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(rd_en && adr_i == cal_mem_pkg::ADR_IRQ_STATUS) |=>
    (irq_status & $past(irq_status)) == $past(irq_status))
    else $error("status bit lost without read");
  a_status_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_en && adr_i == cal_mem_pkg::ADR_IRQ_STATUS && events == '0 |=>
    irq_status == '0)
    else $error("status not cleared by read");
  a_irq_raise: assert property (@(posedge sys_clk) disable iff (!rst_n)
    |(irq_status & irq_mask) |=> irq)
    else $error("unmasked event gave no interrupt");

endmodule : calibration_memory_access_control

//--- testbench/calibration_memory_access_control_tb.sv
// self-checking bench for the calibration memory access control block
`timescale 1ns/10ps
module calibration_memory_access_control_tb;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [9:0] adr_i = 10'h000;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h00000000;
  logic [31:0] dat_o;
  logic ack_o;
  logic err_o;
  logic cal_busy;
  logic irq;
  int fail_count = 0;
  int cmp_count = 0;
  logic [3:0] wr_sel = 4'hF;

  calibration_memory_access_control u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .err_o(err_o), .cal_busy(cal_busy), .irq(irq)
  );

  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // one classic cycle, held until ack or err is sampled high
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge sys_clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= wr_sel;
    dat_i <= d;
    forever begin
      @(posedge sys_clk);
      n++;
      if (ack_o === 1'b1 || err_o === 1'b1 || n > 20) break;
    end
    q = dat_o;
    e = err_o;
    if (n > 20) chk(32'h0, 32'h1, "bus answer");
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask : bus

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    bus(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [31:0] msk, input logic [31:0] exp,
                    input string what);
    logic [31:0] q;
    logic e;
    bus(1'b0, a, 32'h0, q, e);
    chk(q & msk, exp, what);
  endtask : rd

  // reads control until a bit is set, bounded by a read count
  task automatic poll(input int bitn, input int lim, input string what);
    logic [31:0] q;
    logic e;
    for (int i = 0; i < lim; i++) begin
      bus(1'b0, cal_mem_pkg::ADR_CONTROL, 32'h0, q, e);
      if (q[bitn] === 1'b1) return;
    end
    chk(32'h0, 32'h1, what);
  endtask : poll

  task automatic test_reset();
    logic [31:0] q;
    logic e;
    rd(cal_mem_pkg::ADR_CONTROL, 32'hFFFFFFFF, 32'h0, "control reset");
    rd(cal_mem_pkg::ADR_POINTER, 32'hFFFFFFFF, 32'h0, "pointer reset");
    rd(cal_mem_pkg::ADR_VALUE, 32'hFFFFFFFF, 32'h0, "value reset");
    wr(cal_mem_pkg::ADR_CONTROL, 32'h000000A0);
    rd(cal_mem_pkg::ADR_CONTROL, 32'hFFFFFFFF, 32'h0, "done flags read only");
    bus(1'b0, 10'h3F8, 32'h0, q, e);
    chk({31'h0, e}, 32'h1, "unmapped err");
    $display("test reset done");
  endtask : test_reset

  task automatic test_cal();
    wr(cal_mem_pkg::ADR_IRQ_MASK, 32'h1 << cal_mem_pkg::IRQ_CAL_DONE);
    wr(cal_mem_pkg::ADR_CONTROL, 32'h00000040);
    rd(cal_mem_pkg::ADR_CONTROL, 32'hFFFFFFFF, 32'h40, "cal running");
    chk({31'h0, cal_busy}, 32'h1, "cal busy high");
    wr(cal_mem_pkg::ADR_CONTROL, 32'h00000010);
    poll(7, 40, "cal done timeout");
    rd(cal_mem_pkg::ADR_CONTROL, 32'hFFFFFFFF, 32'h80, "cal complete");
    chk({31'h0, cal_busy}, 32'h0, "cal busy low");
    chk({31'h0, irq}, 32'h1, "irq raised");
    rd(cal_mem_pkg::ADR_IRQ_STATUS, 32'hFFFFFFFF, 32'h1, "irq status");
    repeat (3) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    $display("test cal done");
  endtask : test_cal

  task automatic test_fuse();
    wr(cal_mem_pkg::ADR_CONTROL, 32'h00000010);
    rd(cal_mem_pkg::ADR_CONTROL, 32'h30, 32'h10, "fuse running");
    poll(5, 150, "fuse done timeout");
    rd(cal_mem_pkg::ADR_CONTROL, 32'h3E, 32'h20, "fuse complete");
    chk({31'h0, irq}, 32'h0, "masked irq stays low");
    wr(cal_mem_pkg::ADR_POINTER, 32'h000000C5);
    wr(cal_mem_pkg::ADR_CONTROL, 32'h00000002);
    repeat (4) @(posedge sys_clk);
    rd(cal_mem_pkg::ADR_VALUE, 32'hFFFFFFFF, 32'h3A, "fuse word read");
    wr(cal_mem_pkg::ADR_POINTER, 32'h00000042);
    wr(cal_mem_pkg::ADR_CONTROL, 32'h00000004);
    repeat (4) @(posedge sys_clk);
    rd(cal_mem_pkg::ADR_VALUE, 32'hFFFFFFFF, 32'h17, "static copy read");
    $display("test fuse done");
  endtask : test_fuse

  task automatic test_static();
    wr(cal_mem_pkg::ADR_VALUE, 32'h0000002A);
    wr(cal_mem_pkg::ADR_CONTROL, 32'h00000008);
    repeat (4) @(posedge sys_clk);
    rd(cal_mem_pkg::ADR_CONTROL, 32'h0E, 32'h0, "access bits clear");
    wr(cal_mem_pkg::ADR_VALUE, 32'h00000000);
    wr(cal_mem_pkg::ADR_CONTROL, 32'h00000004);
    repeat (4) @(posedge sys_clk);
    rd(cal_mem_pkg::ADR_VALUE, 32'hFFFFFFFF, 32'h2A, "static write back");
    wr(cal_mem_pkg::ADR_POINTER, 32'h00000043);
    wr(cal_mem_pkg::ADR_CONTROL, 32'h00000004);
    repeat (4) @(posedge sys_clk);
    rd(cal_mem_pkg::ADR_VALUE, 32'hFFFFFFFF, 32'h16, "neighbour untouched");
    $display("test static done");
  endtask : test_static

  task automatic test_restart();
    rd(cal_mem_pkg::ADR_IRQ_STATUS, 32'hFFFFFFFF, 32'h6, "fuse and access events");
    rd(cal_mem_pkg::ADR_IRQ_STATUS, 32'hFFFFFFFF, 32'h0, "status read clears");
    rd(cal_mem_pkg::ADR_IRQ_MASK, 32'hFFFFFFFF, 32'h1, "mask read back");
    rd(cal_mem_pkg::ADR_POINTER, 32'hFFFFFFFF, 32'h43, "pointer read back");
    wr_sel = 4'hE;
    wr(cal_mem_pkg::ADR_POINTER, 32'h00000055);
    wr_sel = 4'hF;
    rd(cal_mem_pkg::ADR_POINTER, 32'hFFFFFFFF, 32'h43, "lane 0 off write");
    wr(cal_mem_pkg::ADR_CONTROL, 32'h00000040);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    chk({31'h0, cal_busy}, 32'h0, "busy after reset");
    rd(cal_mem_pkg::ADR_CONTROL, 32'hFFFFFFFF, 32'h0, "control after reset");
    rd(cal_mem_pkg::ADR_POINTER, 32'hFFFFFFFF, 32'h0, "pointer after reset");
    $display("test restart done");
  endtask : test_restart

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  initial begin
    #(40 * 20000);
    fail_count++;
    $display("BAD t=%0t watchdog expired", $time);
    final_report();
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    test_reset();
    test_cal();
    test_fuse();
    test_static();
    test_restart();
    final_report();
  end
endmodule : calibration_memory_access_control_tb
